// *** fpfs_pkg.sv ***
// Constants and carrier types of the floating-point format and status logic.
// Assumes a single 200 MHz ref_clk domain; no other package is needed.
package fpfs_pkg;

  // ----------------------------------------------------------------
  // Register file and formats
  // ----------------------------------------------------------------
  localparam int FPFS_NREG = 8;
  localparam int FPFS_RW = 32;
  localparam logic [7:0] FPFS_BIAS_S = 8'h7F;
  localparam logic [10:0] FPFS_BIAS_D = 11'h3FF;
  localparam logic [31:0] FPFS_FREG_RST = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Status register layout
  // ----------------------------------------------------------------
  localparam int FPFS_TT_LSB = 0;
  localparam int FPFS_TT_MSB = 2;
  localparam int FPFS_UEN_BIT = 3;
  localparam int FPFS_UF_BIT = 4;
  localparam int FPFS_IEN_BIT = 5;
  localparam int FPFS_IF_BIT = 6;
  localparam int FPFS_RM_LSB = 7;
  localparam int FPFS_RM_MSB = 8;
  localparam int FPFS_SWF_LSB = 9;
  localparam int FPFS_SWF_MSB = 15;
  localparam logic [15:0] FPFS_STATUS_RST = 16'h0000;

  // ----------------------------------------------------------------
  // Trap type codes, rounding modes, integer sizes
  // ----------------------------------------------------------------
  localparam logic [2:0] FPFS_TT_NONE = 3'h0;
  localparam logic [2:0] FPFS_TT_UNDER = 3'h1;
  localparam logic [2:0] FPFS_TT_OVER = 3'h2;
  localparam logic [2:0] FPFS_TT_DIVZ = 3'h3;
  localparam logic [2:0] FPFS_TT_ILL = 3'h4;
  localparam logic [2:0] FPFS_TT_INVAL = 3'h5;
  localparam logic [2:0] FPFS_TT_INEXACT = 3'h6;
  localparam logic [1:0] FPFS_RM_NEAR = 2'h0;
  localparam logic [1:0] FPFS_RM_ZERO = 2'h1;
  localparam logic [1:0] FPFS_RM_PINF = 2'h2;
  localparam logic [1:0] FPFS_RM_NINF = 2'h3;
  localparam logic [1:0] FPFS_INT_BYTE = 2'h0;
  localparam logic [1:0] FPFS_INT_WORD = 2'h1;
  localparam logic [1:0] FPFS_INT_DWORD = 2'h2;

  // Illegal encodings: low byte fixed, bits 13:10 one of two values
  localparam logic [7:0] FPFS_ILL_LOW = 8'hBE;
  localparam logic [3:0] FPFS_ILL_MID_A = 4'h3;
  localparam logic [3:0] FPFS_ILL_MID_B = 4'h9;

  // ----------------------------------------------------------------
  // Carrier structs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic we;
    logic dbl;
    logic [2:0] idx;
    logic [63:0] data;
  } fpfs_regwr_s;

  typedef struct packed {
    logic valid;
    logic [21:0] opcode;
    logic dbl;
    logic two_ops;
    logic plain_move;
    logic divide;
    logic status_load;
    logic status_store;
    logic [15:0] load_data;
    logic reg_mode;
    logic fp_operand;
    logic int_dest;
    logic [1:0] int_size;
  } fpfs_instr_s;

  typedef struct packed {
    logic underflow;
    logic overflow;
    logic inexact;
    logic [63:0] result;
    logic signed [63:0] int_result;
    logic sign;
    logic lsb;
    logic guard;
    logic sticky;
  } fpfs_arith_s;

  typedef struct packed {
    logic neg;
    logic zero;
    logic reserved;
    logic signed [11:0] true_exp;
  } fpfs_class_s;

endpackage

// *** fpfs_top.sv ***
// Floating-point operand classification, data registers and status register.
// Assumes the host presents completed instructions with operands and the
// arithmetic flags in one cycle; all inputs are synchronous to ref_clk.
`timescale 1ns/100ps

// What this block does
// - Subtract bias 127 or 1023 from exponent
// - All-ones or denormal exponent is reserved
// - Sign-magnitude; negate flips sign bit only
// - Recognise positive and negative zero
// - Reserved operand traps unless plain move
// - Never deliver infinity, NaN or denormal, except by plain move or integer destination
// - Integers are 8, 16, 32-bit two's complement
// - Eight 32-bit floating-point data registers
// - Double pair: even low, next high
// - Integer register operand goes to CPU
// - Rounding mode field at bits 8:7
// - Underflow traps if enabled, else +0
// - Inexact traps if enabled, else round
// - Trap type cleared on clean completion
// - Underflow always recorded, inexact unless hidden
// - Too large result records overflow code
// - Nonzero divided by zero records divide code
// - Two undefined encodings record illegal code
// - Reserved operand or zero/zero is invalid
// - Other exception hides inexact, flag untouched
// - Sticky underflow flag at bit 4
// - Sticky inexact flag at bit 6
// - Bits 15:9 stored and returned only
module fpfs_top import fpfs_pkg::*; #(
  parameter int NREG = FPFS_NREG
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Data register access
  input wire fpfs_regwr_s reg_wr,
  input wire logic [2:0] reg_rd_idx,
  input wire logic reg_rd_dbl,
  output logic [63:0] reg_rd_data,
  // Instruction completion from the host side
  input wire fpfs_instr_s instr,
  input wire logic [63:0] op_a,
  input wire logic [63:0] op_b,
  input wire fpfs_arith_s arith,
  input wire logic [31:0] int_in,
  // Classification and conversion results
  output fpfs_class_s class_a,
  output fpfs_class_s class_b,
  output logic [63:0] neg_a,
  output logic [31:0] int_ext,
  output logic cpu_xfer,
  // Completion results
  output logic [15:0] status,
  output logic [1:0] round_mode,
  output logic round_inc,
  output logic [63:0] result,
  output logic done,
  output logic trap
);

  typedef struct packed {
    logic [NREG-1:0][31:0] fregs;
    logic [15:0] status;
    logic [63:0] rd_data;
    fpfs_class_s class_a;
    fpfs_class_s class_b;
    logic [63:0] neg_a;
    logic [31:0] int_ext;
    logic cpu_xfer;
    logic round_inc;
    logic [63:0] result;
    logic done;
    logic trap;
  } fpfs_state_s;

  fpfs_state_s s_q;
  fpfs_state_s s_d;

  // ----------------------------------------------------------------
  // Operand classification
  // ----------------------------------------------------------------
  function automatic fpfs_class_s fpfs_classify(input logic [63:0] v, input logic dbl);
    fpfs_class_s c;
    logic ones;
    logic zeros;
    logic fzero;
    c = '0;
    if (dbl) begin
      ones = &v[62:52];
      zeros = ~|v[62:52];
      fzero = ~|v[51:0];
      c.neg = v[63];
      c.true_exp = $signed({1'b0, v[62:52]}) - $signed({1'b0, FPFS_BIAS_D});
    end else begin
      ones = &v[30:23];
      zeros = ~|v[30:23];
      fzero = ~|v[22:0];
      c.neg = v[31];
      c.true_exp = $signed({4'h0, v[30:23]}) - $signed({4'h0, FPFS_BIAS_S});
    end
    c.zero = zeros & fzero;
    c.reserved = ones | (zeros & ~fzero);
    return c;
  endfunction

  fpfs_class_s ca;
  fpfs_class_s cb;
  fpfs_class_s cr;
  logic is_ill;
  logic is_inval;
  logic is_divz;
  logic is_ovf;
  logic is_unf;
  logic is_other;
  logic int_fits;
  logic cpl;
  logic [2:0] tt_code;
  logic underflow_trap_enable;
  logic inexact_trap_enable;
  logic [1:0] rm;
  logic [2:0] even_idx;

  assign underflow_trap_enable = s_q.status[FPFS_UEN_BIT];
  assign inexact_trap_enable = s_q.status[FPFS_IEN_BIT];
  assign rm = s_q.status[FPFS_RM_MSB:FPFS_RM_LSB];
  assign even_idx = {reg_wr.idx[2:1], 1'b0};

  always_comb begin
    ca = fpfs_classify(op_a, instr.dbl);
    cb = fpfs_classify(op_b, instr.dbl);
    cr = fpfs_classify(arith.result, instr.dbl);
    cpl = instr.valid & ~instr.status_load & ~instr.status_store;
    is_ill = (instr.opcode[7:0] == FPFS_ILL_LOW) &&
             ((instr.opcode[13:10] == FPFS_ILL_MID_A) ||
              (instr.opcode[13:10] == FPFS_ILL_MID_B));
    is_inval = ((ca.reserved | (instr.two_ops & cb.reserved)) & ~instr.plain_move) |
               (instr.divide & ca.zero & cb.zero);
    is_divz = instr.divide & ca.zero & ~cb.zero;
    case (instr.int_size)
      FPFS_INT_BYTE: int_fits = (&arith.int_result[63:7]) | ~(|arith.int_result[63:7]);
      FPFS_INT_WORD: int_fits = (&arith.int_result[63:15]) | ~(|arith.int_result[63:15]);
      default: int_fits = (&arith.int_result[63:31]) | ~(|arith.int_result[63:31]);
    endcase
    // an all-ones result exponent leaves the block only on a plain move or an integer destination
    is_ovf = arith.overflow | (instr.int_dest & ~int_fits) |
             (~instr.int_dest & ~instr.plain_move & cr.reserved & ~cr.zero &
              (instr.dbl ? (&arith.result[62:52]) : (&arith.result[30:23])));
    // a denormal result counts as underflow
    is_unf = arith.underflow | (~instr.int_dest & ~instr.plain_move & cr.reserved &
             ~is_ovf & ~arith.overflow);
    is_other = is_ill | is_inval | is_divz | is_ovf | is_unf;
    // Priority: an illegal form is never executed, so no other trap code applies
    if (is_ill) begin
      tt_code = FPFS_TT_ILL;
    end else if (is_inval) begin
      tt_code = FPFS_TT_INVAL;
    end else if (is_divz) begin
      tt_code = FPFS_TT_DIVZ;
    end else if (is_ovf) begin
      tt_code = FPFS_TT_OVER;
    end else if (is_unf) begin
      tt_code = FPFS_TT_UNDER;
    end else if (arith.inexact) begin
      tt_code = FPFS_TT_INEXACT;
    end else begin
      tt_code = FPFS_TT_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.trap = 1'b0;
    if (reg_wr.we) begin
      if (reg_wr.dbl) begin
        // low half even, high half next
        s_d.fregs[even_idx] = reg_wr.data[31:0];
        s_d.fregs[even_idx + 3'h1] = reg_wr.data[63:32];
      end else begin
        s_d.fregs[reg_wr.idx] = reg_wr.data[31:0];
      end
    end
    if (reg_rd_dbl) begin
      s_d.rd_data = {s_q.fregs[{reg_rd_idx[2:1], 1'b1}], s_q.fregs[{reg_rd_idx[2:1], 1'b0}]};
    end else begin
      s_d.rd_data = {32'h0000_0000, s_q.fregs[reg_rd_idx]};
    end
    s_d.class_a = ca;
    s_d.class_b = cb;
    s_d.neg_a = op_a;
    if (instr.dbl) begin
      s_d.neg_a[63] = ~op_a[63];
    end else begin
      s_d.neg_a[31] = ~op_a[31];
    end
    case (instr.int_size)
      FPFS_INT_BYTE: s_d.int_ext = {{24{int_in[7]}}, int_in[7:0]};
      FPFS_INT_WORD: s_d.int_ext = {{16{int_in[15]}}, int_in[15:0]};
      default: s_d.int_ext = int_in;
    endcase
    // integer register operand is a CPU register
    s_d.cpu_xfer = instr.reg_mode & ~instr.fp_operand;
    case (rm)
      FPFS_RM_NEAR: s_d.round_inc = arith.guard & (arith.sticky | arith.lsb);
      FPFS_RM_ZERO: s_d.round_inc = 1'b0;
      FPFS_RM_PINF: s_d.round_inc = (arith.guard | arith.sticky) & ~arith.sign;
      FPFS_RM_NINF: s_d.round_inc = (arith.guard | arith.sticky) & arith.sign;
      default: s_d.round_inc = 1'b0;
    endcase
    if (instr.valid) begin
      s_d.done = 1'b1;
      if (instr.status_load) begin
        // load is the only software clear
        // load is the only software clear
        s_d.status = instr.load_data;
      end else if (!instr.status_store) begin
        s_d.status[FPFS_TT_MSB:FPFS_TT_LSB] = tt_code;
        if (is_unf) begin
          s_d.status[FPFS_UF_BIT] = 1'b1;
        end
        if (arith.inexact && !is_other) begin
          s_d.status[FPFS_IF_BIT] = 1'b1;
        end
        s_d.trap = is_ill | is_inval | is_divz | is_ovf | (is_unf & underflow_trap_enable) |
                   (arith.inexact & ~is_other & inexact_trap_enable);
        if (is_ovf || is_unf || is_inval || is_ill || is_divz) begin
          s_d.result = 64'h0000_0000_0000_0000;
        end else begin
          s_d.result = arith.result;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_q <= '0;
      s_q.status <= FPFS_STATUS_RST;
      for (int i = 0; i < NREG; i++) begin
        s_q.fregs[i] <= FPFS_FREG_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rd_data = s_q.rd_data;
  assign class_a = s_q.class_a;
  assign class_b = s_q.class_b;
  assign neg_a = s_q.neg_a;
  assign int_ext = s_q.int_ext;
  assign cpu_xfer = s_q.cpu_xfer;
  assign status = s_q.status;
  assign round_mode = rm;
  assign round_inc = s_q.round_inc;
  assign result = s_q.result;
  assign done = s_q.done;
  assign trap = s_q.trap;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_reset_status;
    @(posedge ref_clk) disable iff (1'b0) rst |=> (status == FPFS_STATUS_RST) && !trap;
  endproperty
  a_reset_status: assert property (p_reset_status) else $error("status not cleared by reset");

  property p_trap_code;
    trap |-> (status[FPFS_TT_MSB:FPFS_TT_LSB] != FPFS_TT_NONE) && done;
  endproperty
  a_trap_code: assert property (p_trap_code) else $error("trap without a trap code");

  property p_uf_sticky;
    status[FPFS_UF_BIT] && !(instr.valid && instr.status_load) |=> status[FPFS_UF_BIT];
  endproperty
  a_uf_sticky: assert property (p_uf_sticky) else $error("underflow flag lost");

  property p_unf_code;
    cpl && is_unf && !is_ill && !is_inval && !is_divz && !is_ovf |=>
      (status[FPFS_TT_MSB:FPFS_TT_LSB] == FPFS_TT_UNDER) && status[FPFS_UF_BIT] &&
      (trap == $past(underflow_trap_enable));
  endproperty
  a_unf_code: assert property (p_unf_code) else $error("underflow not recorded");

  property p_unf_zero;
    cpl && arith.underflow && !underflow_trap_enable && !is_ill && !is_inval && !is_divz && !is_ovf |=>
      (result == 64'h0000_0000_0000_0000) && !trap;
  endproperty
  a_unf_zero: assert property (p_unf_zero) else $error("disabled underflow not +0");

  property p_inexact_hidden;
    cpl && arith.inexact && is_other |=>
      (status[FPFS_IF_BIT] == $past(status[FPFS_IF_BIT])) &&
      (status[FPFS_TT_MSB:FPFS_TT_LSB] != FPFS_TT_INEXACT);
  endproperty
  a_inexact_hidden: assert property (p_inexact_hidden) else $error("inexact not hidden");

  property p_divz;
    cpl && !is_ill && !is_inval && instr.divide && ca.zero && !cb.zero |=>
      (status[FPFS_TT_MSB:FPFS_TT_LSB] == FPFS_TT_DIVZ) && trap;
  endproperty
  a_divz: assert property (p_divz) else $error("divide by zero not recorded");

  property p_round_zero;
    rm == FPFS_RM_ZERO |=> !round_inc;
  endproperty
  a_round_zero: assert property (p_round_zero) else $error("round toward zero incremented");

  property p_pair_write;
    reg_wr.we && reg_wr.dbl ##1 !reg_wr.we && reg_rd_dbl && reg_rd_idx == $past(even_idx) |=>
      reg_rd_data == $past(reg_wr.data, 2);
  endproperty
  a_pair_write: assert property (p_pair_write) else $error("register pair order wrong");

  property p_swf_kept;
    instr.valid && instr.status_load ##1 !(instr.valid && instr.status_load) |->
      status[FPFS_SWF_MSB:FPFS_SWF_LSB] == $past(instr.load_data[FPFS_SWF_MSB:FPFS_SWF_LSB]);
  endproperty
  a_swf_kept: assert property (p_swf_kept) else $error("software field altered");

  property p_illegal;
    cpl && is_ill |=> (status[FPFS_TT_MSB:FPFS_TT_LSB] == FPFS_TT_ILL) && trap;
  endproperty
  a_illegal: assert property (p_illegal) else $error("illegal form not recorded");

  property p_ovf_zero;
    cpl && !is_ill && !is_inval && !is_divz && is_ovf |=>
      (status[FPFS_TT_MSB:FPFS_TT_LSB] == FPFS_TT_OVER) && trap &&
      (result == 64'h0000_0000_0000_0000);
  endproperty
  a_ovf_zero: assert property (p_ovf_zero) else $error("overflow not recorded");

  c_underflow_trap: cover property (cpl && is_unf && underflow_trap_enable ##1 trap);
  c_inexact_quiet: cover property (cpl && arith.inexact && !is_other && !inexact_trap_enable ##1 done);
  c_illegal: cover property (instr.valid && is_ill ##1 trap);

endmodule // fpfs_top

// *** fpfs_host_model.sv ***
// Host-side model: issues register accesses and completing instructions.
// Assumes the bench calls its tasks; signals change only after a falling edge.
`timescale 1ns/100ps
module fpfs_host_model import fpfs_pkg::*; (
  // Clock
  input wire logic ref_clk,
  // Register access towards the block
  output fpfs_regwr_s reg_wr,
  output logic [2:0] reg_rd_idx,
  output logic reg_rd_dbl,
  // Instruction completion towards the block
  output fpfs_instr_s instr,
  output logic [63:0] op_a,
  output logic [63:0] op_b,
  output fpfs_arith_s arith,
  output logic [31:0] int_in
);
  initial begin
    reg_wr = '0;
    reg_rd_idx = 3'h0;
    reg_rd_dbl = 1'b0;
    instr = '0;
    op_a = 64'h0;
    op_b = 64'h0;
    arith = '0;
    int_in = 32'h0;
  end

  // pair named by its even index
  task automatic wr_reg(input logic dbl, input logic [2:0] idx, input logic [63:0] d);
    @(negedge ref_clk);
    reg_wr <= '{we: 1'b1, dbl: dbl, idx: (dbl ? {idx[2:1], 1'b0} : idx), data: d};
    @(negedge ref_clk);
    reg_wr.we <= 1'b0;
  endtask

  // Select is a level; data shows one edge later
  task automatic rd_sel(input logic dbl, input logic [2:0] idx);
    @(negedge ref_clk);
    reg_rd_dbl <= dbl;
    reg_rd_idx <= idx;
    @(negedge ref_clk);
  endtask

  // Operands stay as levels; only the valid pulse is dropped
  task automatic exec(input fpfs_instr_s i, input logic [63:0] a, input logic [63:0] b,
                      input fpfs_arith_s ar, input logic [31:0] ii);
    @(negedge ref_clk);
    instr <= i;
    op_a <= a;
    op_b <= b;
    arith <= ar;
    int_in <= ii;
    @(negedge ref_clk);
    instr.valid <= 1'b0;
  endtask
endmodule // fpfs_host_model

// *** fpfs_top_tb.sv ***
// Self-checking bench for the format and status logic.
// Assumes the host model drives all inputs except clock and reset.
`timescale 1ns/100ps
module fpfs_top_tb import fpfs_pkg::*;;
  logic ref_clk;
  logic rst;
  fpfs_regwr_s reg_wr;
  logic [2:0] reg_rd_idx;
  logic reg_rd_dbl;
  logic [63:0] reg_rd_data;
  fpfs_instr_s instr;
  logic [63:0] op_a;
  logic [63:0] op_b;
  fpfs_arith_s arith;
  logic [31:0] int_in;
  fpfs_class_s class_a;
  fpfs_class_s class_b;
  logic [63:0] ar_res = 64'h3F80_0000;
  logic [63:0] neg_a;
  logic [31:0] int_ext;
  logic cpu_xfer;
  logic [15:0] status;
  logic [1:0] round_mode;
  logic round_inc;
  logic [63:0] result;
  logic done;
  logic trap;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  fpfs_host_model host (.ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd_idx(reg_rd_idx),
    .reg_rd_dbl(reg_rd_dbl), .instr(instr), .op_a(op_a), .op_b(op_b), .arith(arith),
    .int_in(int_in));

  fpfs_top #(.NREG(FPFS_NREG)) dut (.ref_clk(ref_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd_idx(reg_rd_idx), .reg_rd_dbl(reg_rd_dbl), .reg_rd_data(reg_rd_data),
    .instr(instr), .op_a(op_a), .op_b(op_b), .arith(arith), .int_in(int_in),
    .class_a(class_a), .class_b(class_b), .neg_a(neg_a), .int_ext(int_ext),
    .cpu_xfer(cpu_xfer),
    .status(status), .round_mode(round_mode), .round_inc(round_inc), .result(result),
    .done(done), .trap(trap));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Hang guard
  // ----------------------------------------------------------------
  // Whole run is well under a thousand cycles
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles >= 5000) begin
      mismatches++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Completing instruction with arithmetic flags {underflow, overflow, inexact}
  task automatic run(input logic [21:0] opc, input logic [2:0] f, input logic div,
                     input logic mv, input logic [63:0] a, input logic [63:0] b,
                     input logic [15:0] st, input logic tr);
    fpfs_instr_s i;
    fpfs_arith_s ar;
    i = '0;
    ar = '0;
    i.valid = 1'b1;
    i.opcode = opc;
    i.divide = div;
    i.two_ops = div;
    i.plain_move = mv;
    i.fp_operand = 1'b1;
    {ar.underflow, ar.overflow, ar.inexact} = f;
    ar.result = ar_res;
    host.exec(i, a, b, ar, 32'h0);
    chk("done", {63'h0, done}, 64'h1);
    chk("status", {48'h0, status}, {48'h0, st});
    chk("trap", {63'h0, trap}, {63'h0, tr});
  endtask

  task automatic ld(input logic [15:0] v);
    fpfs_instr_s i;
    i = '0;
    i.valid = 1'b1;
    i.status_load = 1'b1;
    i.load_data = v;
    host.exec(i, 64'h0, 64'h0, '0, 32'h0);
    chk("status", {48'h0, status}, {48'h0, v});
    chk("round_mode", {62'h0, round_mode}, {62'h0, v[8:7]});
  endtask

  // Classification flags are {neg, zero, reserved}
  task automatic cls(input logic [63:0] a, input logic dbl, input logic [2:0] f,
                     input logic [11:0] e);
    fpfs_instr_s i;
    i = '0;
    i.dbl = dbl;
    i.reg_mode = 1'b1;
    i.fp_operand = 1'b1;
    host.exec(i, a, a, '0, 32'h0);
    chk("class", {61'h0, class_a.neg, class_a.zero, class_a.reserved}, {61'h0, f});
    chk("class_b", {61'h0, class_b.neg, class_b.zero, class_b.reserved}, {61'h0, f});
    chk("cpu_xfer", {63'h0, cpu_xfer}, 64'h0);
    if (f == 3'h0 || f == 3'h4) begin
      chk("true_exp", {52'h0, class_a.true_exp}, {52'h0, e});
    end
    chk("neg_a", neg_a, a ^ (dbl ? 64'h8000_0000_0000_0000 : 64'h8000_0000));
  endtask

  task automatic intx(input logic [1:0] sz, input logic [31:0] v, input logic [31:0] e);
    fpfs_instr_s i;
    i = '0;
    i.int_size = sz;
    i.reg_mode = 1'b1;
    host.exec(i, 64'h0, 64'h0, '0, v);
    chk("int_ext", {32'h0, int_ext}, {32'h0, e});
    chk("cpu_xfer", {63'h0, cpu_xfer}, 64'h1);
  endtask

  task automatic rnd(input logic [1:0] m, input logic s);
    fpfs_arith_s ar;
    logic e;
    ar = '0;
    ar.sign = s;
    ar.lsb = 1'b1;
    ar.guard = 1'b1;
    e = (m == FPFS_RM_NEAR) | (m == FPFS_RM_PINF & ~s) | (m == FPFS_RM_NINF & s);
    host.exec('0, 64'h0, 64'h0, ar, 32'h0);
    chk("round_inc", {63'h0, round_inc}, {63'h0, e});
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    chk("status", {48'h0, status}, 64'h0);
    host.rd_sel(1'b1, 3'h2);
    chk("pair_rst", reg_rd_data, 64'h0);
    host.wr_reg(1'b1, 3'h3, 64'hCAFE_0001_1234_5678);
    host.wr_reg(1'b0, 3'h7, 64'hFFFF_FFFF_A5A5_5A5A);
    host.rd_sel(1'b1, 3'h2);
    chk("pair", reg_rd_data, 64'hCAFE_0001_1234_5678);
    host.rd_sel(1'b0, 3'h3);
    chk("high_half", reg_rd_data, 64'hCAFE_0001);
    host.rd_sel(1'b0, 3'h7);
    chk("single", reg_rd_data, 64'hA5A5_5A5A);
    cls(64'h4040_0000, 1'b0, 3'h0, 12'h001);
    cls(64'hBFE8_0000_0000_0000, 1'b1, 3'h4, 12'hFFF);
    cls(64'h8000_0000, 1'b0, 3'h6, 12'h0);
    cls(64'h0, 1'b0, 3'h2, 12'h0);
    cls(64'h7F80_0000, 1'b0, 3'h1, 12'h0);
    cls(64'h0000_0001, 1'b0, 3'h1, 12'h0);
    intx(FPFS_INT_BYTE, 32'h0000_0080, 32'hFFFF_FF80);
    intx(FPFS_INT_WORD, 32'h0001_7FFF, 32'h0000_7FFF);
    intx(FPFS_INT_DWORD, 32'h8000_0000, 32'h8000_0000);
    for (int m = 0; m < 4; m++) begin
      ld({7'h0, m[1:0], 7'h0});
      rnd(m[1:0], 1'b0);
      rnd(m[1:0], 1'b1);
    end
    ld(16'hAA88);
    run(22'h0, 3'h4, 1'b0, 1'b0, 64'h0, 64'h0, 16'hAA99, 1'b1);
    run(22'h0, 3'h0, 1'b0, 1'b0, 64'h0, 64'h0, 16'hAA98, 1'b0);
    run(22'h0, 3'h1, 1'b0, 1'b0, 64'h0, 64'h0, 16'hAADE, 1'b0);
    run(22'h0, 3'h3, 1'b0, 1'b0, 64'h0, 64'h0, 16'hAADA, 1'b1);
    run(22'h0, 3'h0, 1'b1, 1'b0, 64'h0, 64'h3F80_0000, 16'hAADB, 1'b1);
    run(22'h0, 3'h0, 1'b1, 1'b0, 64'h0, 64'h0, 16'hAADD, 1'b1);
    run(22'h000CBE, 3'h0, 1'b0, 1'b0, 64'h0, 64'h0, 16'hAADC, 1'b1);
    run(22'h0024BE, 3'h0, 1'b0, 1'b0, 64'h0, 64'h0, 16'hAADC, 1'b1);
    run(22'h0, 3'h0, 1'b0, 1'b0, 64'h7F80_0000, 64'h0, 16'hAADD, 1'b1);
    run(22'h0, 3'h0, 1'b0, 1'b1, 64'h7F80_0000, 64'h0, 16'hAAD8, 1'b0);
    ld(16'h0000);
    run(22'h0, 3'h4, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0011, 1'b0);
    chk("result", result, 64'h0);
    ld(16'h0020);
    run(22'h0, 3'h1, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0066, 1'b1);
    ar_res = 64'h7F80_0000;
    run(22'h0, 3'h0, 1'b0, 1'b0, 64'h0, 64'h0, 16'h0062, 1'b1);
    chk("result", result, 64'h0);
    @(negedge ref_clk);
    rst = 1'b1;
    @(negedge ref_clk);
    rst = 1'b0;
    chk("status", {48'h0, status}, 64'h0);
    chk("rst_reg", reg_rd_data, 64'h0);
    complete_run();
  end
endmodule // fpfs_top_tb
